/* File: verilog/hp_pkg.sv */
package hp_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_WIDE_PORT     = 8'h08;
    localparam logic [7:0] IDX_CTRL_PORT     = 8'h09;
    localparam logic [7:0] IDX_INT_CTRL      = 8'h0B;
    localparam logic [7:0] IDX_PERIPH_FLAG   = 8'h0C;
    localparam logic [7:0] IDX_WIDE_DIR      = 8'h88;
    localparam logic [7:0] IDX_CTRL_DIR      = 8'h89;
    localparam logic [7:0] IDX_PERIPH_EN     = 8'h8C;
    localparam logic [7:0] IDX_ANALOG_CFG    = 8'h9F;

    // Reset values
    localparam logic [7:0] RST_WIDE_OUT      = 8'h00;
    localparam logic [7:0] RST_WIDE_DIR      = 8'hFF;
    localparam logic [2:0] RST_CTRL_OUT      = 3'h0;
    localparam logic [2:0] RST_CTRL_DIR      = 3'h7;
    localparam logic [7:0] RST_INT_CTRL      = 8'h00;
    localparam logic [7:0] RST_PERIPH_FLAG   = 8'h00;
    localparam logic [7:0] RST_PERIPH_EN     = 8'h00;
    localparam logic [2:0] RST_ANALOG_SEL    = 3'h0;

    // Field positions
    localparam int unsigned BIT_INPUT_FULL   = 7;
    localparam int unsigned BIT_OUT_PENDING  = 6;
    localparam int unsigned BIT_OVERRUN      = 5;
    localparam int unsigned BIT_HOST_SEL     = 4;
    localparam int unsigned BIT_HP_IRQ       = 7;

    // Control pin positions in slave-port mode
    localparam int unsigned PIN_RD           = 0;
    localparam int unsigned PIN_WR           = 1;
    localparam int unsigned PIN_CS           = 2;

    // Analog select bits that must be set for digital control pins
    localparam logic [2:0] ANALOG_DIG_MASK   = 3'h6;

    // Internal phase clock counter values
    localparam logic [1:0] PHASE_TWO         = 2'h1;
    localparam logic [1:0] PHASE_FOUR        = 2'h3;

    // Completion stage of a host transfer, Gray along the path
    typedef enum logic [1:0] {
        HP_IDLE    = 2'b00,
        HP_WAIT_P2 = 2'b01,
        HP_WAIT_P4 = 2'b11
    } hp_stage_t;

    // Control-port direction and status register layout
    typedef struct packed {
        logic       input_full;
        logic       output_pending;
        logic       input_overrun;
        logic       host_port_select;
        logic       unused;
        logic [2:0] dir;
    } hp_ctrl_dir_t;

    // Wide port pad drive
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } hp_pad_t;

endpackage

/* File: verilog/hp_parallel_slave_port.sv */
`timescale 1ns/1ps
module hp_parallel_slave_port
(
    // Clock, reset, enable
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               ce,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [9:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Wide port pins
    input  wire logic [7:0]         wide_pin_in,
    output hp_pkg::hp_pad_t         wide_pad,
    // Control port pins
    input  wire logic [2:0]         ctrl_pin_in,
    output logic      [2:0]         ctrl_pin_out,
    output logic      [2:0]         ctrl_pin_oe,
    // Interrupt request
    output logic                    host_port_irq
);
    import hp_pkg::*;

    // Software visible state
    logic [7:0]   wide_out_r;
    logic [7:0]   wide_dir_r;
    logic [2:0]   ctrl_out_r;
    logic [2:0]   ctrl_dir_r;
    logic         host_sel_r;
    logic         in_full_r;
    logic         out_pend_r;
    logic         overrun_r;
    logic [7:0]   int_ctrl_r;
    logic [7:0]   periph_flag_r;
    logic [7:0]   periph_en_r;
    logic [2:0]   analog_r;
    logic [7:0]   in_latch_r;

    // Strobe tracking
    logic [2:0]   sync1_r;
    logic [2:0]   sync2_r;
    logic         wr_act_r;
    logic         rd_act_r;
    logic [1:0]   phase_r;
    hp_stage_t    wr_stage_r;
    hp_stage_t    rd_stage_r;

    // Output flops
    logic [31:0]  prdata_r;
    logic         pready_r;
    logic         pslverr_r;
    hp_pad_t      pad_r;
    logic [2:0]   ctrl_oe_r;
    logic         irq_r;

    // Next values
    logic         in_full_nxt;
    logic         out_pend_nxt;
    logic         overrun_nxt;
    logic [7:0]   periph_flag_nxt;
    hp_pad_t      pad_nxt;
    logic [7:0]   rd_mux;

    // Completion stage step: wait next phase two, fire on phase four after it
    function automatic hp_stage_t stage_next(input hp_stage_t st, input logic ev,
                                             input logic [1:0] ph);
        case (st)
            HP_IDLE:    stage_next = ev ? HP_WAIT_P2 : HP_IDLE;
            HP_WAIT_P2: stage_next = (ph == PHASE_TWO) ? HP_WAIT_P4 : HP_WAIT_P2;
            HP_WAIT_P4: stage_next = (ph == PHASE_FOUR) ? HP_IDLE : HP_WAIT_P4;
            default:    stage_next = HP_IDLE;
        endcase
    endfunction

    // Address decode
    wire [7:0] acc_idx   = paddr[9:2];
    wire       aligned   = (paddr[1:0] == 2'b00);
    wire       hit_wide  = aligned && (acc_idx == IDX_WIDE_PORT);
    wire       hit_ctrl  = aligned && (acc_idx == IDX_CTRL_PORT);
    wire       hit_int   = aligned && (acc_idx == IDX_INT_CTRL);
    wire       hit_pflag = aligned && (acc_idx == IDX_PERIPH_FLAG);
    wire       hit_wdir  = aligned && (acc_idx == IDX_WIDE_DIR);
    wire       hit_cdir  = aligned && (acc_idx == IDX_CTRL_DIR);
    wire       hit_pen   = aligned && (acc_idx == IDX_PERIPH_EN);
    wire       hit_an    = aligned && (acc_idx == IDX_ANALOG_CFG);
    wire       mapped    = hit_wide | hit_ctrl | hit_int | hit_pflag
                         | hit_wdir | hit_cdir | hit_pen | hit_an;

    // Bus phases; effects only at the completing access edge
    wire       setup     = psel & ~penable;
    wire       acc_done  = psel & penable & pready_r;
    wire       wr_acc    = acc_done & pwrite & mapped;
    wire       rd_acc    = acc_done & ~pwrite & mapped;
    wire       wr_wide   = wr_acc & hit_wide;
    wire       wr_cdir   = wr_acc & hit_cdir;
    wire       wr_pflag  = wr_acc & hit_pflag;
    wire       rd_wide   = rd_acc & hit_wide;

    // Synchronised strobes, active low
    wire       cs_s      = sync2_r[PIN_CS];
    wire       wr_s      = sync2_r[PIN_WR];
    wire       rd_s      = sync2_r[PIN_RD];
    wire       wr_act    = host_sel_r & ~cs_s & ~wr_s;
    wire       rd_act    = host_sel_r & ~cs_s & ~rd_s;
    wire       wr_start  = wr_act & ~wr_act_r;
    wire       rd_start  = rd_act & ~rd_act_r;
    wire       wr_end    = ~wr_act & wr_act_r;
    wire       rd_end    = ~rd_act & rd_act_r;
    wire       wr_done   = (wr_stage_r == HP_WAIT_P4) && (phase_r == PHASE_FOUR);
    wire       rd_done   = (rd_stage_r == HP_WAIT_P4) && (phase_r == PHASE_FOUR);

    // Control pins read digital only when select bits allow it
    wire       ctrl_dig  = ((analog_r & ANALOG_DIG_MASK) == ANALOG_DIG_MASK);
    wire [2:0] ctrl_rd   = ctrl_pin_in & {3{ctrl_dig}};

    // Direction and status word, bit 3 always zero
    hp_ctrl_dir_t ctrl_dir_view;
    assign ctrl_dir_view.input_full       = in_full_r;
    assign ctrl_dir_view.output_pending   = out_pend_r;
    assign ctrl_dir_view.input_overrun    = overrun_r;
    assign ctrl_dir_view.host_port_select = host_sel_r;
    assign ctrl_dir_view.unused           = 1'b0;
    assign ctrl_dir_view.dir              = ctrl_dir_r;

    // Read data selection
    assign rd_mux = hit_wide  ? (host_sel_r ? in_latch_r : wide_pin_in) :
                    hit_ctrl  ? {5'h00, ctrl_rd} :
                    hit_int   ? int_ctrl_r :
                    hit_pflag ? periph_flag_r :
                    hit_wdir  ? wide_dir_r :
                    hit_cdir  ? ctrl_dir_view :
                    hit_pen   ? periph_en_r :
                    hit_an    ? {5'h00, analog_r} : 8'h00;

    // Status flag next values; a set beats a clear, except that leaving slave mode clears full and pending
    assign in_full_nxt  = !host_sel_r ? 1'b0 :
                          wr_done     ? 1'b1 :
                          rd_wide     ? 1'b0 : in_full_r;
    assign out_pend_nxt = !host_sel_r ? 1'b0 :
                          wr_wide     ? 1'b1 :
                          rd_start    ? 1'b0 : out_pend_r;
    assign overrun_nxt  = (wr_start && in_full_r) ? 1'b1 :
                          wr_cdir ? pwdata[BIT_OVERRUN] : overrun_r;

    // Peripheral flags; completion sets the host-port bit over a write
    always_comb
    begin
        periph_flag_nxt = wr_pflag ? pwdata[7:0] : periph_flag_r;
        if (wr_done || rd_done)
        begin
            periph_flag_nxt[BIT_HP_IRQ] = 1'b1;
        end
    end

    // Wide pad drive; strobes own direction in slave mode
    assign pad_nxt.out = wide_out_r;
    assign pad_nxt.oe  = host_sel_r ? {8{rd_act}} : ~wide_dir_r;

    // Strobe synchroniser, second stage only is used
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_r <= 3'h7;
            sync2_r <= 3'h7;
        end
        else if (ce)
        begin
            sync1_r <= ctrl_pin_in;
            sync2_r <= sync1_r;
        end
    end

    // Phase counter and transfer edge history
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            phase_r  <= 2'h0;
            wr_act_r <= 1'b0;
            rd_act_r <= 1'b0;
        end
        else if (ce)
        begin
            phase_r  <= phase_r + 2'h1;
            wr_act_r <= wr_act;
            rd_act_r <= rd_act;
        end
    end

    // Completion stages for write and read
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_stage_r <= HP_IDLE;
            rd_stage_r <= HP_IDLE;
        end
        else if (ce)
        begin
            wr_stage_r <= stage_next(wr_stage_r, wr_end, phase_r);
            rd_stage_r <= stage_next(rd_stage_r, rd_end, phase_r);
        end
    end

    // Incoming latch follows the bus while the host writes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            in_latch_r <= 8'h00;
        end
        else if (ce && wr_act)
        begin
            in_latch_r <= wide_pin_in;
        end
    end

    // Port latches and direction registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wide_out_r <= RST_WIDE_OUT;
            wide_dir_r <= RST_WIDE_DIR;
            ctrl_out_r <= RST_CTRL_OUT;
            ctrl_dir_r <= RST_CTRL_DIR;
            host_sel_r <= 1'b0;
        end
        else if (ce)
        begin
            if (wr_wide)
                wide_out_r <= pwdata[7:0];
            if (wr_acc && hit_wdir)
                wide_dir_r <= pwdata[7:0];
            if (wr_acc && hit_ctrl)
                ctrl_out_r <= pwdata[2:0];
            if (wr_cdir)
            begin
                ctrl_dir_r <= pwdata[2:0];
                host_sel_r <= pwdata[BIT_HOST_SEL];
            end
        end
    end

    // Status flags
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            in_full_r  <= 1'b0;
            out_pend_r <= 1'b0;
            overrun_r  <= 1'b0;
        end
        else if (ce)
        begin
            in_full_r  <= in_full_nxt;
            out_pend_r <= out_pend_nxt;
            overrun_r  <= overrun_nxt;
        end
    end

    // Interrupt and analog configuration registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            int_ctrl_r    <= RST_INT_CTRL;
            periph_flag_r <= RST_PERIPH_FLAG;
            periph_en_r   <= RST_PERIPH_EN;
            analog_r      <= RST_ANALOG_SEL;
        end
        else if (ce)
        begin
            periph_flag_r <= periph_flag_nxt;
            if (wr_acc && hit_int)
                int_ctrl_r <= pwdata[7:0];
            if (wr_acc && hit_pen)
                periph_en_r <= pwdata[7:0];
            if (wr_acc && hit_an)
                analog_r <= pwdata[2:0];
        end
    end

    // APB answer: ready and data prepared in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else if (ce)
        begin
            pready_r  <= setup;
            pslverr_r <= setup & ~mapped;
            if (setup)
                prdata_r <= {24'h00_0000, rd_mux};
        end
    end

    // Pin drive and interrupt output
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pad_r     <= '0;
            ctrl_oe_r <= 3'h0;
            irq_r     <= 1'b0;
        end
        else if (ce)
        begin
            pad_r     <= pad_nxt;
            ctrl_oe_r <= host_sel_r ? 3'h0 : ~ctrl_dir_r;
            irq_r     <= periph_flag_r[BIT_HP_IRQ] & periph_en_r[BIT_HP_IRQ];
        end
    end

    // Outputs straight from flops
    assign prdata        = prdata_r;
    assign pready        = pready_r;
    assign pslverr       = pslverr_r;
    assign wide_pad      = pad_r;
    assign ctrl_pin_out  = ctrl_out_r;
    assign ctrl_pin_oe   = ctrl_oe_r;
    assign host_port_irq = irq_r;

endmodule

/* File: test/hp_host_model.sv */
`timescale 1ns/1ps
module hp_host_model
(
    // Clock
    input  wire logic       pclk,
    // Host strobes, bus drive and bus level
    output logic      [2:0] strobe_n,
    output logic      [7:0] bus,
    input  wire logic [7:0] bus_in
);
    logic       drv_r;
    logic [7:0] dat_r;

    // Released bus shows the inverse of the last value
    assign bus = drv_r ? dat_r : ~dat_r;

    // Idle: strobes high, bus released
    initial
    begin
        strobe_n = 3'h7;
        drv_r = 1'b0;
        dat_r = 8'h00;
    end

    // Drive the pins as a plain external level
    task automatic put(input logic [7:0] v);
        drv_r <= 1'b1;
        dat_r <= v;
    endtask

    // Select and write low with data, then raise both
    task automatic write_byte(input logic [7:0] v);
        @(posedge pclk);
        drv_r <= 1'b1;
        dat_r <= v;
        strobe_n <= 3'h1;
        repeat (4) @(posedge pclk);
        strobe_n <= 3'h7;
        repeat (12) @(posedge pclk);
        drv_r <= 1'b0;
    endtask

    // Select and read low, take the byte, then raise both
    task automatic read_byte(output logic [7:0] v);
        @(posedge pclk);
        drv_r <= 1'b0;
        strobe_n <= 3'h2;
        repeat (6) @(posedge pclk);
        v = bus_in;
        strobe_n <= 3'h7;
        repeat (12) @(posedge pclk);
    endtask
endmodule

/* File: test/hp_parallel_slave_port_monitor.sv */
`timescale 1ns/1ps
module hp_parallel_slave_port_monitor
    import hp_pkg::*;
(
    // Clock, reset, enable
    input wire logic            pclk,
    input wire logic            presetn,
    input wire logic            ce,
    // APB
    input wire logic            psel,
    input wire logic            penable,
    input wire logic            pwrite,
    input wire logic [9:0]      paddr,
    input wire logic [31:0]     pwdata,
    input wire logic [31:0]     prdata,
    input wire logic            pready,
    input wire logic            pslverr,
    // Pins
    input wire logic [7:0]      wide_pin_in,
    input wire hp_pkg::hp_pad_t wide_pad,
    input wire logic [2:0]      ctrl_pin_in,
    input wire logic [2:0]      ctrl_pin_out,
    input wire logic [2:0]      ctrl_pin_oe,
    input wire logic            host_port_irq
);
    logic       mode_r;
    logic       en_r;
    logic [7:0] wdir_r;
    logic [2:0] cdir_r;
    logic       acc_w;
    logic       fw_w;

    // Completed writes and flag or enable traffic
    assign acc_w = psel && penable && pwrite && pready;
    assign fw_w  = psel && pwrite
                && (paddr[9:2] == IDX_PERIPH_FLAG || paddr[9:2] == IDX_PERIPH_EN);

    // Shadow of mode, directions and interrupt enable
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            mode_r <= 1'b0;
            cdir_r <= RST_CTRL_DIR;
            wdir_r <= RST_WIDE_DIR;
            en_r   <= 1'b0;
        end
        else if (acc_w)
        begin
            if (paddr[9:2] == IDX_CTRL_DIR) {mode_r, cdir_r} <= {pwdata[BIT_HOST_SEL], pwdata[2:0]};
            if (paddr[9:2] == IDX_WIDE_DIR) wdir_r <= pwdata[7:0];
            if (paddr[9:2] == IDX_PERIPH_EN) en_r <= pwdata[BIT_HP_IRQ];
        end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    setup_ready_a:
        assert property (psel && !penable |=> pready) else $error("no ready after setup");
    ready_pulse_a:
        assert property (pready |=> !pready) else $error("ready held too long");
    read_width_a:
        assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
    refused_zero_a:
        assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad refusal");
    gp_wide_oe_a:
        assert property (!mode_r && $stable(wdir_r) && $stable(mode_r) |-> wide_pad.oe == ~wdir_r)
            else $error("wide drive not from direction");
    gp_ctrl_oe_a:
        assert property (!mode_r && $stable(cdir_r) && $stable(mode_r) |-> ctrl_pin_oe == ~cdir_r)
            else $error("control drive not from direction");
    slave_ctrl_in_a:
        assert property (mode_r |=> ctrl_pin_oe == 3'h0) else $error("control pin driven");
    slave_idle_a:
        assert property ((mode_r && ctrl_pin_in[PIN_CS]) [*6] |-> wide_pad.oe == 8'h00)
            else $error("wide pins driven without read");
    read_drive_a:
        assert property ((mode_r && !ctrl_pin_in[PIN_CS] && !ctrl_pin_in[PIN_RD]) [*6]
            |-> wide_pad.oe == 8'hFF) else $error("read not driven");
    irq_mask_a:
        assert property (!en_r && $stable(en_r) |-> !host_port_irq) else $error("masked irq");
    irq_hold_a:
        assert property (host_port_irq && en_r && !fw_w && !$past(fw_w) |=> host_port_irq)
            else $error("irq dropped alone");

    // Main scenarios reached
    cover property (host_port_irq);
    cover property (pslverr);
    cover property (mode_r && wide_pad.oe == 8'hFF);
endmodule

/* File: test/parallel_slave_port_io_bench.sv */
`timescale 1ns/1ps
`define CHK(n, x, a) \
    begin \
        checked++; \
        if ((a) !== (x)) \
        begin \
            failures++; \
            $display("[ERR] %s exp %h got %h", n, x, a); \
        end \
    end
module parallel_slave_port_io_bench;
    import hp_pkg::*;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [9:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  wide_pin_in;
    hp_pad_t     wide_pad;
    logic [2:0]  ctrl_pin_in;
    logic [2:0]  ctrl_pin_out;
    logic [2:0]  ctrl_pin_oe;
    logic        host_port_irq;
    logic [2:0]  strobe_n;
    logic [7:0]  host_bus;
    logic [8:0]  notes[$];
    logic [8:0]  note;
    logic [7:0]  d;
    logic [7:0]  e;
    int          seed;
    int          failures;
    int          checked;

    // Pin levels from every driver
    assign wide_pin_in = (wide_pad.oe & wide_pad.out) | (~wide_pad.oe & host_bus);
    assign ctrl_pin_in = (ctrl_pin_oe & ctrl_pin_out) | (~ctrl_pin_oe & strobe_n);

    hp_parallel_slave_port hp_parallel_slave_port_i
    (
        .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wide_pin_in(wide_pin_in), .wide_pad(wide_pad),
        .ctrl_pin_in(ctrl_pin_in), .ctrl_pin_out(ctrl_pin_out), .ctrl_pin_oe(ctrl_pin_oe),
        .host_port_irq(host_port_irq)
    );

    hp_host_model hp_host_model_i
    (
        .pclk(pclk), .strobe_n(strobe_n), .bus(host_bus), .bus_in(wide_pin_in)
    );

    // Clock
    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task automatic print_verdict();
        if (failures == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // One APB transfer; reads leave their expectation as a note
    task automatic apb(input logic [7:0] i, input logic w, input logic [7:0] v,
                       input logic [8:0] x);
        int n;
        if (!w) notes.push_back(x);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= {24'h0, v};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            failures++;
            print_verdict();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] i, input logic [7:0] v);
        apb(i, 1'b1, v, 9'h0);
    endtask

    task automatic rd(input logic [7:0] i, input logic [7:0] x);
        apb(i, 1'b0, 8'h00, {1'b0, x});
    endtask

    // Compare each read answer with the oldest note
    always @(posedge pclk)
        if (psel && penable && pready && !pwrite && notes.size() > 0)
        begin
            note = notes.pop_front();
            `CHK("read", note, {pslverr, prdata[7:0]})
        end

    // Main sequence
    initial
    begin
        seed = 32'h2EF95720;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 10'h000;
        pwdata = 32'h0;
        failures = 0;
        checked = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(IDX_WIDE_DIR, 8'hFF);
        rd(IDX_CTRL_DIR, 8'h07);
        rd(IDX_PERIPH_FLAG, 8'h00);
        rd(IDX_PERIPH_EN, 8'h00);
        rd(IDX_INT_CTRL, 8'h00);
        rd(IDX_ANALOG_CFG, 8'h00);
        rd(IDX_CTRL_PORT, 8'h00);
        apb(8'h0A, 1'b0, 8'h00, 9'h100);
        d = $random(seed);
        hp_host_model_i.put(d);
        wr(IDX_WIDE_DIR, 8'h0F);
        wr(IDX_WIDE_PORT, d ^ 8'hA5);
        repeat (2) @(posedge pclk);
        rd(IDX_WIDE_PORT, {d[7:4] ^ 4'hA, d[3:0]});
        `CHK("pad_oe", 8'hF0, wide_pad.oe)
        wr(IDX_ANALOG_CFG, 8'h06);
        wr(IDX_CTRL_DIR, 8'hC8);
        wr(IDX_CTRL_PORT, 8'h05);
        repeat (2) @(posedge pclk);
        rd(IDX_CTRL_PORT, 8'h05);
        wr(IDX_ANALOG_CFG, 8'h02);
        rd(IDX_CTRL_PORT, 8'h00);
        wr(IDX_ANALOG_CFG, 8'h07);
        rd(IDX_CTRL_DIR, 8'h00);
        wr(IDX_CTRL_DIR, 8'hDF);
        rd(IDX_CTRL_DIR, 8'h17);
        wr(IDX_PERIPH_EN, 8'h80);
        d = $random(seed);
        hp_host_model_i.write_byte(d);
        rd(IDX_CTRL_DIR, 8'h97);
        rd(IDX_PERIPH_FLAG, 8'h80);
        `CHK("irq", 1'b1, host_port_irq)
        e = $random(seed);
        hp_host_model_i.write_byte(e);
        rd(IDX_CTRL_DIR, 8'hB7);
        rd(IDX_WIDE_PORT, e);
        rd(IDX_CTRL_DIR, 8'h37);
        wr(IDX_PERIPH_FLAG, 8'h00);
        rd(IDX_PERIPH_FLAG, 8'h00);
        d = $random(seed);
        wr(IDX_WIDE_PORT, d);
        rd(IDX_CTRL_DIR, 8'h77);
        hp_host_model_i.read_byte(e);
        `CHK("host_read", d, e)
        rd(IDX_CTRL_DIR, 8'h37);
        rd(IDX_PERIPH_FLAG, 8'h80);
        wr(IDX_PERIPH_EN, 8'h00);
        wr(IDX_WIDE_PORT, 8'h3C);
        wr(IDX_CTRL_DIR, 8'h27);
        rd(IDX_CTRL_DIR, 8'h27);
        wr(IDX_CTRL_DIR, 8'h07);
        rd(IDX_CTRL_DIR, 8'h07);
        print_verdict();
    end
endmodule

bind hp_parallel_slave_port hp_parallel_slave_port_monitor mon_i
(
    .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .wide_pin_in, .wide_pad, .ctrl_pin_in, .ctrl_pin_out, .ctrl_pin_oe,
    .host_port_irq
);
